//--- design/apr_pkg.sv
// Constants and types shared by the analog front-end control registers.
package apr_pkg;

  // Register addresses on the serial register port.
  localparam logic [7:0] AFE_CTRL_ADDR   = 8'h1a;
  localparam logic [7:0] RSVD_FIRST_ADDR = 8'h1b;
  localparam logic [7:0] RSVD_LAST_ADDR  = 8'h1e;
  localparam logic [7:0] SOFT_RST_ADDR   = 8'h1f;

  // Reset value and writable bits of the converter interface register.
  localparam logic [7:0] AFE_CTRL_RESET = 8'h82;
  localparam logic [7:0] AFE_CTRL_WMASK = 8'hfe;

  // Field positions inside the converter interface register.
  localparam int unsigned CLAMP_MSB        = 7;
  localparam int unsigned CLAMP_LSB        = 6;
  localparam int unsigned SYNC_T_BIT       = 5;
  localparam int unsigned GAIN_DIS_BIT     = 4;
  localparam int unsigned CLK_SLEEP_BIT    = 3;
  localparam int unsigned LUMA_SLEEP_BIT   = 2;
  localparam int unsigned CHROMA_SLEEP_BIT = 1;
  localparam int unsigned RSVD_BIT         = 0;

  // Back-porch clamp targets selected by the two-bit clamp code.
  localparam logic [7:0] CLAMP_LEVEL_0 = 8'h30;
  localparam logic [7:0] CLAMP_LEVEL_1 = 8'h34;
  localparam logic [7:0] CLAMP_LEVEL_2 = 8'h38;
  localparam logic [7:0] CLAMP_LEVEL_3 = 8'h3c;

  // Values returned where the read data is otherwise undefined.
  localparam logic [7:0] RSVD_READ_VALUE     = 8'h00;
  localparam logic [7:0] SOFT_RST_READ_VALUE = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;

  // Wake recovery time after the system clock is restored.
  localparam int unsigned SYS_CLK_HZ       = 200_000_000;
  localparam int unsigned RECOVERY_TIME_MS = 1000;
  localparam int unsigned RECOVERY_CYCLES  =
    (SYS_CLK_HZ / 1000) * RECOVERY_TIME_MS;
  localparam int unsigned RECOVERY_CNT_W   = 28;

  // States of the wake recovery sequencer.
  typedef enum logic [1:0] {
    WAKE_RUN     = 2'b00,
    WAKE_SLEEP   = 2'b01,
    WAKE_RECOVER = 2'b10
  } apr_wake_e;

endpackage : apr_pkg

//--- design/apr_wake_timer.sv
// Wake recovery sequencer for the system clock power-down state.
`timescale 1ns/1ps

module apr_wake_timer
  import apr_pkg::*;
#(
  parameter int unsigned CNT_W       = RECOVERY_CNT_W,
  parameter int unsigned WAKE_CYCLES = RECOVERY_CYCLES
)(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic ce_i,
  input  wire logic sleep_i,
  output logic      ready_o
);

  typedef struct packed {
    apr_wake_e        state;
    logic [CNT_W-1:0] cnt;
    logic             ready;
  } apr_wake_s;

  localparam logic [CNT_W-1:0] WAKE_LAST = CNT_W'(WAKE_CYCLES - 1);

  apr_wake_s wake_r;
  apr_wake_s wake_nxt;

  // Ready only drops while asleep and during the recovery count after wake.
  always_comb
  begin
    wake_nxt = wake_r;
    case (wake_r.state)
      WAKE_RUN:
      begin
        wake_nxt.ready = 1'b1;
        if (sleep_i)
        begin
          wake_nxt.state = WAKE_SLEEP;
          wake_nxt.ready = 1'b0;
        end
      end
      WAKE_SLEEP:
      begin
        wake_nxt.ready = 1'b0;
        wake_nxt.cnt   = '0;
        if (!sleep_i)
        begin
          wake_nxt.state = WAKE_RECOVER;
        end
      end
      WAKE_RECOVER:
      begin
        wake_nxt.ready = 1'b0;
        if (sleep_i)
        begin
          wake_nxt.state = WAKE_SLEEP;
          wake_nxt.cnt   = '0;
        end
        else if (wake_r.cnt == WAKE_LAST)
        begin
          wake_nxt.state = WAKE_RUN;
          wake_nxt.ready = 1'b1;
          wake_nxt.cnt   = '0;
        end
        else
        begin
          wake_nxt.cnt = wake_r.cnt + CNT_W'(1);
        end
      end
      default:
      begin
        wake_nxt.state = WAKE_RUN;
        wake_nxt.cnt   = '0;
        wake_nxt.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wake_r.state <= WAKE_RUN;
      wake_r.cnt   <= '0;
      wake_r.ready <= 1'b1;
    end
    else if (ce_i)
    begin
      wake_r <= wake_nxt;
    end
  end

  assign ready_o = wake_r.ready;

endmodule : apr_wake_timer

//--- design/apr_regs.sv
// Converter interface register, reserved range and software reset command.
`timescale 1ns/1ps

module apr_regs
  import apr_pkg::*;
#(
  parameter bit          HAS_CHROMA  = 1'b1,
  parameter int unsigned WAKE_CYCLES = RECOVERY_CYCLES
)(
  input  wire logic       CLK_SYS_I,
  input  wire logic       RST_I,
  input  wire logic       CE_I,
  input  wire logic [7:0] REG_ADDR_I,
  input  wire logic       REG_WR_I,
  input  wire logic [7:0] REG_WDATA_I,
  input  wire logic       REG_RD_I,
  output logic      [7:0] REG_RDATA_O,
  output logic            REG_RVALID_O,
  output logic      [7:0] CLAMP_LEVEL_O,
  output logic            SYNC_THRESH_LOW_O,
  output logic            GAIN_CONTROL_RUN_O,
  output logic            SYS_CLK_RUN_O,
  output logic            SYS_CLK_READY_O,
  output logic            LUMA_SLEEP_O,
  output logic            CHROMA_SLEEP_O,
  output logic            SOFT_RESET_O
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rdata;
    logic       rvalid;
    logic [7:0] clamp_level;
    logic       sync_low;
    logic       gain_run;
    logic       clk_run;
    logic       luma_sleep;
    logic       chroma_sleep;
    logic       soft_rst;
  } apr_regs_s;

  // The chroma sleep bit is frozen at its reset value when the converter
  // is absent, so writes to it have no effect on that variant.
  localparam logic [7:0] CHROMA_MASK = 8'h02;
  localparam logic [7:0] WR_MASK     =
    HAS_CHROMA ? AFE_CTRL_WMASK : (AFE_CTRL_WMASK & ~CHROMA_MASK);

  apr_regs_s regs_r;
  apr_regs_s regs_nxt;

  logic wr_ctrl;
  logic wr_soft_rst;
  logic wr_rsvd;
  logic wake_ready;

  always_comb
  begin
    wr_ctrl     = 1'b0;
    wr_soft_rst = 1'b0;
    wr_rsvd     = 1'b0;
    if (REG_WR_I && REG_ADDR_I == AFE_CTRL_ADDR)
    begin
      wr_ctrl = 1'b1;
    end
    else if (REG_WR_I && REG_ADDR_I == SOFT_RST_ADDR)
    begin
      wr_soft_rst = 1'b1;
    end
    else if (REG_WR_I && REG_ADDR_I >= RSVD_FIRST_ADDR &&
             REG_ADDR_I <= RSVD_LAST_ADDR)
    begin
      wr_rsvd = 1'b1;
    end
  end

  always_comb
  begin
    regs_nxt = regs_r;

    // Writes to the reserved range are dropped; the host must not issue them.
    if (wr_rsvd)
    begin
      regs_nxt.ctrl = regs_r.ctrl;
    end

    // Soft reset wins over everything and ignores the data value.
    if (wr_soft_rst)
    begin
      regs_nxt.ctrl = AFE_CTRL_RESET;
    end
    else if (wr_ctrl)
    begin
      // Bit 0 is reserved and never stored, whatever the host sends.
      regs_nxt.ctrl = (REG_WDATA_I & WR_MASK) |
                      (regs_r.ctrl & ~WR_MASK);
      regs_nxt.ctrl[RSVD_BIT] = 1'b0;
    end
    regs_nxt.soft_rst = wr_soft_rst;

    // Reads answer one cycle later; no register has a read side effect.
    regs_nxt.rvalid = REG_RD_I;
    regs_nxt.rdata  = regs_r.rdata;
    if (REG_RD_I)
    begin
      if (REG_ADDR_I == AFE_CTRL_ADDR)
      begin
        regs_nxt.rdata = regs_r.ctrl;
      end
      else if (REG_ADDR_I == SOFT_RST_ADDR)
      begin
        regs_nxt.rdata = SOFT_RST_READ_VALUE;
      end
      else if (REG_ADDR_I >= RSVD_FIRST_ADDR &&
               REG_ADDR_I <= RSVD_LAST_ADDR)
      begin
        regs_nxt.rdata = RSVD_READ_VALUE;
      end
      else
      begin
        regs_nxt.rdata = UNMAPPED_READ_VALUE;
      end
    end

    // Decoded controls follow the new register value in the same cycle.
    case (regs_nxt.ctrl[CLAMP_MSB:CLAMP_LSB])
      2'h0: regs_nxt.clamp_level = CLAMP_LEVEL_0;
      2'h1: regs_nxt.clamp_level = CLAMP_LEVEL_1;
      2'h2: regs_nxt.clamp_level = CLAMP_LEVEL_2;
      default: regs_nxt.clamp_level = CLAMP_LEVEL_3;
    endcase
    regs_nxt.sync_low   = regs_nxt.ctrl[SYNC_T_BIT];
    regs_nxt.gain_run   = ~regs_nxt.ctrl[GAIN_DIS_BIT];
    regs_nxt.clk_run    = ~regs_nxt.ctrl[CLK_SLEEP_BIT];
    regs_nxt.luma_sleep = regs_nxt.ctrl[LUMA_SLEEP_BIT];
    // Without a chroma converter it stays parked asleep.
    regs_nxt.chroma_sleep = HAS_CHROMA ?
      regs_nxt.ctrl[CHROMA_SLEEP_BIT] : 1'b1;
  end

  // The register file stays on this clock, so it remains reachable while the
  // decoder's system clock is shut down.
  always_ff @(posedge CLK_SYS_I)
  begin
    if (RST_I)
    begin
      regs_r.ctrl         <= AFE_CTRL_RESET;
      regs_r.rdata        <= 8'h00;
      regs_r.rvalid       <= 1'b0;
      regs_r.clamp_level  <= CLAMP_LEVEL_2;
      regs_r.sync_low     <= 1'b0;
      regs_r.gain_run     <= 1'b1;
      regs_r.clk_run      <= 1'b1;
      regs_r.luma_sleep   <= 1'b0;
      regs_r.chroma_sleep <= 1'b1;
      regs_r.soft_rst     <= 1'b0;
    end
    else if (CE_I)
    begin
      regs_r <= regs_nxt;
    end
  end

  // Ready stays low while asleep and for the full recovery time after wake.
  apr_wake_timer #(
    .CNT_W       (RECOVERY_CNT_W),
    .WAKE_CYCLES (WAKE_CYCLES)
  ) u_wake (
    .clk_i   (CLK_SYS_I),
    .rst_i   (RST_I),
    .ce_i    (CE_I),
    .sleep_i (~regs_r.clk_run),
    .ready_o (wake_ready)
  );

  assign REG_RDATA_O        = regs_r.rdata;
  assign REG_RVALID_O       = regs_r.rvalid;
  assign CLAMP_LEVEL_O      = regs_r.clamp_level;
  assign SYNC_THRESH_LOW_O  = regs_r.sync_low;
  assign GAIN_CONTROL_RUN_O = regs_r.gain_run;
  assign SYS_CLK_RUN_O      = regs_r.clk_run;
  assign SYS_CLK_READY_O    = wake_ready;
  assign LUMA_SLEEP_O       = regs_r.luma_sleep;
  assign CHROMA_SLEEP_O     = regs_r.chroma_sleep;
  assign SOFT_RESET_O       = regs_r.soft_rst;

endmodule : apr_regs

//--- tb/apr_regs_checker.sv
// Assertions on the converter interface register block.
`timescale 1ns/1ps
module apr_regs_checker
  import apr_pkg::*;
(
  input wire logic       CLK_SYS_I,
  input wire logic       RST_I,
  input wire logic       CE_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic       REG_WR_I,
  input wire logic [7:0] REG_WDATA_I,
  input wire logic       REG_RD_I,
  input wire logic       REG_RVALID_O,
  input wire logic [7:0] CLAMP_LEVEL_O,
  input wire logic       SYNC_THRESH_LOW_O,
  input wire logic       GAIN_CONTROL_RUN_O,
  input wire logic       SYS_CLK_RUN_O,
  input wire logic       SYS_CLK_READY_O,
  input wire logic       LUMA_SLEEP_O,
  input wire logic       CHROMA_SLEEP_O,
  input wire logic       SOFT_RESET_O
);
  wire wc = CE_I && REG_WR_I && REG_ADDR_I == AFE_CTRL_ADDR;
  wire ws = CE_I && REG_WR_I && REG_ADDR_I == SOFT_RST_ADDR;
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  rd_answer_a: assert property (CE_I && REG_RD_I |=> REG_RVALID_O)
    else $error("no read answer");
  clamp_map_a: assert property (wc |=> CLAMP_LEVEL_O ==
    8'h30 + {4'h0, $past(REG_WDATA_I[7:6]), 2'b00}) else $error("clamp");
  sync_sel_a: assert property (wc |=>
    SYNC_THRESH_LOW_O == $past(REG_WDATA_I[5])) else $error("sync");
  gain_sense_a: assert property (wc |=>
    GAIN_CONTROL_RUN_O != $past(REG_WDATA_I[4])) else $error("gain");
  clk_sleep_a: assert property (wc |=>
    SYS_CLK_RUN_O != $past(REG_WDATA_I[3])) else $error("clk run");
  ready_drop_a: assert property ($fell(SYS_CLK_RUN_O) && CE_I |=>
    !SYS_CLK_READY_O) else $error("ready");
  sleep_bits_a: assert property (wc |=>
    {LUMA_SLEEP_O, CHROMA_SLEEP_O} == $past(REG_WDATA_I[2:1]))
    else $error("sleep bits");
  soft_reset_a: assert property (ws |=> SOFT_RESET_O &&
    CLAMP_LEVEL_O == 8'h38 && CHROMA_SLEEP_O) else $error("soft reset");
endmodule : apr_regs_checker
bind apr_regs apr_regs_checker i_apr_regs_checker (.*);

//--- tb/apr_host_model.sv
// Host model driving the register port one transfer at a time.
`timescale 1ns/1ps
module apr_host_model
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  input  wire logic       rvalid_i,
  output logic      [7:0] addr_o  = 8'h00,
  output logic            wr_o    = 1'b0,
  output logic      [7:0] wdata_o = 8'h00,
  output logic            rd_o    = 1'b0
);
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    if (a >= 8'h1b && a <= 8'h1e) return;
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= {d[7:1], 1'b0};
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a; // Released lines are inverted so stale data never matches.
    wdata_o <= ~d;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d,
                        output logic v);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    @(posedge clk_i);
    d = rdata_i;
    v = rvalid_i;
  endtask : rd_reg
endmodule : apr_host_model

//--- tb/testbench.sv
// Self-checking bench for the converter interface register block.
`timescale 1ns/1ps
module testbench
  import apr_pkg::*;
;
  localparam int unsigned WC = 16;
  logic       clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic       wr, rd, rvld, s_low, g_run, c_run, c_rdy, luma, chrm, srst;
  logic       rd_v;
  logic [7:0] addr, wdata, rdata, clamp, rd_d;
  int         n_fail = 0, total_checks = 0;
  apr_regs #(.WAKE_CYCLES(WC)) i_apr_regs (
    .CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce), .REG_ADDR_I(addr),
    .REG_WR_I(wr), .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .REG_RVALID_O(rvld), .CLAMP_LEVEL_O(clamp), .SYNC_THRESH_LOW_O(s_low),
    .GAIN_CONTROL_RUN_O(g_run), .SYS_CLK_RUN_O(c_run), .LUMA_SLEEP_O(luma),
    .SYS_CLK_READY_O(c_rdy), .CHROMA_SLEEP_O(chrm), .SOFT_RESET_O(srst));
  apr_host_model i_apr_host_model (.clk_i(clk), .rdata_i(rdata),
    .rvalid_i(rvld), .addr_o(addr), .wr_o(wr), .wdata_o(wdata), .rd_o(rd));
  task automatic give_verdict(input int to);
    n_fail += to;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    n_fail += int'(got !== exp);
    if (got !== exp)
      $display("ERROR at %0t got %h exp %h", $time, got, exp);
  endtask : chk
  task automatic chk_ctl(input logic [7:0] v);
    chk(clamp, 8'h30 + {4'h0, v[7:6], 2'b00});
    chk({s_low, g_run, c_run}, {v[5], ~v[4:3]});
    chk({luma, chrm}, v[2:1]);
    i_apr_host_model.rd_reg(AFE_CTRL_ADDR, rd_d, rd_v);
    chk({rd_v, rd_d}, {1'b1, v});
  endtask : chk_ctl
  task automatic t_fields;
    logic [7:0] tbl [4] = '{8'h00, 8'h66, 8'hb4, 8'hf6};
    chk_ctl(8'h82);
    foreach (tbl[i])
    begin
      i_apr_host_model.wr_reg(AFE_CTRL_ADDR, tbl[i]);
      #1;
      chk_ctl(tbl[i]);
    end
  endtask : t_fields
  task automatic t_sleep;
    int n = 0;
    i_apr_host_model.wr_reg(AFE_CTRL_ADDR, 8'h8a);
    #1;
    chk_ctl(8'h8a);
    chk(c_rdy, 1'b0);
    i_apr_host_model.wr_reg(AFE_CTRL_ADDR, 8'h82);
    #1;
    while (c_rdy !== 1'b1 && n < 4 * WC) #5 n++;
    chk(n >= WC, 1'b1);
    chk(n <= WC + 2, 1'b1);
    chk(c_rdy, 1'b1);
  endtask : t_sleep
  task automatic t_srst;
    for (int a = 8'h1b; a <= 8'h1f; a++)
    begin
      i_apr_host_model.rd_reg(a[7:0], rd_d, rd_v);
      chk({rd_v, rd_d}, 9'h100);
    end
    i_apr_host_model.wr_reg(AFE_CTRL_ADDR, 8'h7c);
    #1;
    chk_ctl(8'h7c);
    i_apr_host_model.wr_reg(SOFT_RST_ADDR, 8'ha4);
    #1;
    chk(srst, 1'b1);
    @(posedge clk);
    #1;
    chk(srst, 1'b0);
    chk_ctl(8'h82);
  endtask : t_srst
  // With the enable low neither the write nor the read may be taken, so the
  // read answer stays low and the last read data is still shown.
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    i_apr_host_model.wr_reg(AFE_CTRL_ADDR, 8'h24);
    i_apr_host_model.rd_reg(SOFT_RST_ADDR, rd_d, rd_v);
    chk({rd_v, rd_d}, 9'h082);
    @(posedge clk);
    ce <= 1'b1;
    #1;
    chk_ctl(8'h82);
  endtask : t_freeze
  initial forever #2.5 clk = ~clk;
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_fields();
    t_sleep();
    t_srst();
    t_freeze();
    give_verdict(0);
  end
  initial #20000 give_verdict(1);
endmodule : testbench
